// file: hw/dcwb_consts.svh
// Constants of the device configuration word bank
`ifndef DCWB_CONSTS_SVH
`define DCWB_CONSTS_SVH
// -------------------------------------------------------------------------
// Register indices (byte address on APB is four times the index)
// -------------------------------------------------------------------------
`define DCWB_IDX_CPU_CLOCK_PROTECT  24'h300001
`define DCWB_IDX_OSCILLATOR_SELECT  24'h300002
`define DCWB_IDX_WATCHDOG_POSTSCALE 24'h300003
`define DCWB_IDX_DEEP_SLEEP_OPTIONS 24'h300004
`define DCWB_IDX_PERIPHERAL_OPTIONS 24'h300005
`define DCWB_IDX_FLASH_PROTECT_PAGE 24'h300006
`define DCWB_IDX_FLASH_PROTECT_MODE 24'h300007
`define DCWB_NUM_REGS               7
// -------------------------------------------------------------------------
// Implemented bit masks and reset values
// -------------------------------------------------------------------------
`define DCWB_MASK_CPU_CLOCK_PROTECT  8'h07
`define DCWB_MASK_OSCILLATOR_SELECT  8'hFF
`define DCWB_MASK_WATCHDOG_POSTSCALE 8'h0F
`define DCWB_MASK_DEEP_SLEEP_OPTIONS 8'hFF
`define DCWB_MASK_PERIPHERAL_OPTIONS 8'h0B
`define DCWB_MASK_FLASH_PROTECT_PAGE 8'hFF
`define DCWB_MASK_FLASH_PROTECT_MODE 8'h0B
`define DCWB_RESET_BYTE              8'hFF
// -------------------------------------------------------------------------
// Field positions
// -------------------------------------------------------------------------
`define DCWB_BIT_CODE_PROTECT_N     2
`define DCWB_BIT_TWO_SPEED          7
`define DCWB_BIT_FAIL_SAFE          6
`define DCWB_BIT_CLOCK_OUT_EN       5
`define DCWB_BIT_DS_WD_ENABLE       3
`define DCWB_BIT_DS_BROWNOUT        2
`define DCWB_BIT_RTC_REF            1
`define DCWB_BIT_DS_WD_REF          0
`define DCWB_BIT_ADDR_MASK_MODE     3
`define DCWB_BIT_CONVERTER_RES      1
`define DCWB_BIT_PIN_LOCK_ONE_WAY   0
`define DCWB_BIT_CFG_PAGE_PROTECT_N 7
`define DCWB_BIT_USB_LS_CLOCK       3
`define DCWB_BIT_RANGE_DIRECTION    1
`define DCWB_BIT_PROTECT_DISABLE    0
// -------------------------------------------------------------------------
// Fixed figures
// -------------------------------------------------------------------------
`define DCWB_DS_WD_PRESCALE         32
`define DCWB_FLASH_PAGE_SHIFT       10
`define DCWB_CONFIG_PAGE            7'h3F
`define DCWB_USB_DIV_48MHZ          4'h8
`define DCWB_USB_DIV_24MHZ          4'h4
`endif

// file: hw/dcwb_pkg.sv
// Types shared by the device configuration word bank
`default_nettype none
package dcwb_pkg;
    typedef enum logic [1:0] {
        DCWB_SRC_INTERNAL,
        DCWB_SRC_CRYSTAL,
        DCWB_SRC_EXTERNAL
    } dcwb_osc_src_e;

    typedef enum logic [1:0] {
        DCWB_SOSC_RESERVED,
        DCWB_SOSC_LOW_POWER,
        DCWB_SOSC_DIGITAL,
        DCWB_SOSC_HIGH_POWER
    } dcwb_sosc_e;

    typedef enum logic [1:0] {
        DCWB_LD_ISSUE,
        DCWB_LD_CAPTURE,
        DCWB_LD_DONE
    } dcwb_load_st_e;

    typedef struct packed {
        logic [2:0]    cpu_clock_divide_ratio;
        logic          code_protected;
        logic          two_speed_startup_en;
        logic          fail_safe_monitor_en;
        logic          clock_out_signal_en;
        dcwb_osc_src_e osc_source;
        logic          osc_pll_sel;
        dcwb_sosc_e    secondary_osc_power;
        logic [3:0]    watchdog_postscale_log2;
        logic          deep_sleep_wd_enable;
        logic [4:0]    deep_sleep_wd_postscale_log2;
        logic          brownout_in_deep_sleep;
        logic          brownout_always;
        logic          rtc_ref_secondary;
        logic          deep_sleep_wd_ref_internal;
        logic          serial_addr_mask_7bit;
        logic          converter_10bit;
        logic          pin_lock_one_way;
        logic [3:0]    low_speed_usb_divide;
    } dcwb_settings_s;
endpackage : dcwb_pkg
`default_nettype wire

// file: hw/dcwb_config_bank.sv
// Device configuration word bank: load, APB access, decoded settings
//
// Implementation choice: the APB interface to the registers.
`include "dcwb_consts.svh"
`default_nettype none
module dcwb_config_bank (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [23:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output var  logic                    pready,
    output var  logic [31:0]             prdata,
    output var  logic                    pslverr,
    output var  logic                    nv_rd_en,
    output var  logic [2:0]              nv_rd_index,
    input  wire logic [7:0]              nv_rd_data,
    output var  logic                    load_done,
    input  wire logic                    low_voltage_variant,
    input  wire logic                    pin_select_unlocked,
    input  wire logic                    pin_select_lock_set,
    input  wire logic                    pin_select_lock_clear,
    output var  logic                    pin_select_lock,
    output var  logic                    pin_select_write_allow,
    input  wire logic [16:0]             flash_byte_addr,
    output var  logic                    flash_page_protected,
    output var  dcwb_pkg::dcwb_settings_s settings
);
    import dcwb_pkg::*;

    // ---------------------------------------------------------------------
    // Decode helpers
    // ---------------------------------------------------------------------
    function automatic logic [7:0] mask_of(input logic [2:0] idx);
        logic [7:0] m;
        m = 8'h00;
        case (idx)
            3'h0: m = `DCWB_MASK_CPU_CLOCK_PROTECT;
            3'h1: m = `DCWB_MASK_OSCILLATOR_SELECT;
            3'h2: m = `DCWB_MASK_WATCHDOG_POSTSCALE;
            3'h3: m = `DCWB_MASK_DEEP_SLEEP_OPTIONS;
            3'h4: m = `DCWB_MASK_PERIPHERAL_OPTIONS;
            3'h5: m = `DCWB_MASK_FLASH_PROTECT_PAGE;
            3'h6: m = `DCWB_MASK_FLASH_PROTECT_MODE;
            default: m = 8'h00;
        endcase
        return m;
    endfunction : mask_of

    // Returns {hit, index}; an unaligned address never hits
    function automatic logic [3:0] decode_addr(input logic [23:0] a);
        logic [21:0] off;
        off = a[23:2] - 22'(`DCWB_IDX_CPU_CLOCK_PROTECT);
        if (a[1:0] == 2'h0 && off < 22'(`DCWB_NUM_REGS)) begin
            return {1'b1, off[2:0]};
        end
        return 4'h0;
    endfunction : decode_addr

    // ---------------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------------
    logic [7:0]    cfg_r [`DCWB_NUM_REGS];
    logic [7:0]    cfg_nxt [`DCWB_NUM_REGS];
    logic [`DCWB_NUM_REGS-1:0] written_r;
    logic [`DCWB_NUM_REGS-1:0] written_nxt;
    dcwb_load_st_e ld_st_r;
    dcwb_load_st_e ld_st_nxt;
    logic [2:0]    ld_idx_r;
    logic          lv_meta_r;
    logic          lv_sync_r;
    logic          lv_strap_r;

    // ---------------------------------------------------------------------
    // Load sequence
    // ---------------------------------------------------------------------
    // Runs once after every reset; no path re-enters it afterwards
    wire logic ld_capture = (ld_st_r == DCWB_LD_CAPTURE);
    wire logic ld_last    = (ld_idx_r == 3'(`DCWB_NUM_REGS - 1));

    always_comb begin
        case (ld_st_r)
            // Wait for the request flop, so byte 0 is really asked for
            DCWB_LD_ISSUE:   ld_st_nxt = nv_rd_en ? DCWB_LD_CAPTURE
                                                  : DCWB_LD_ISSUE;
            DCWB_LD_CAPTURE: ld_st_nxt = ld_last ? DCWB_LD_DONE
                                                 : DCWB_LD_ISSUE;
            DCWB_LD_DONE:    ld_st_nxt = DCWB_LD_DONE;
            default:         ld_st_nxt = DCWB_LD_DONE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ld_st_r     <= DCWB_LD_ISSUE;
            ld_idx_r    <= 3'h0;
            nv_rd_en    <= 1'b0;
            nv_rd_index <= 3'h0;
            load_done   <= 1'b0;
        end else begin
            ld_st_r     <= ld_st_nxt;
            ld_idx_r    <= ld_capture ? ld_idx_r + 3'h1 : ld_idx_r;
            nv_rd_en    <= (ld_st_nxt == DCWB_LD_ISSUE);
            nv_rd_index <= (ld_capture && !ld_last) ? ld_idx_r + 3'h1
                                                    : ld_idx_r;
            load_done   <= (ld_st_nxt == DCWB_LD_DONE);
        end
    end

    // Strap is synchronised, then held from the end of the load onward
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lv_meta_r  <= 1'b0;
            lv_sync_r  <= 1'b0;
            lv_strap_r <= 1'b0;
        end else begin
            lv_meta_r  <= low_voltage_variant;
            lv_sync_r  <= lv_meta_r;
            lv_strap_r <= load_done ? lv_strap_r : lv_sync_r;
        end
    end

    // ---------------------------------------------------------------------
    // APB slave
    // ---------------------------------------------------------------------
    // One wait state per access; held off entirely until the load ends
    wire logic [3:0] dec      = decode_addr(paddr);
    wire logic       hit      = dec[3];
    wire logic [2:0] hit_idx  = dec[2:0];
    wire logic       access   = psel && penable;
    wire logic       answer   = access && !pready && load_done;
    wire logic       commit   = access && pready && pwrite && hit;
    wire logic [7:0] rd_byte  = hit ? (cfg_r[hit_idx] & mask_of(hit_idx))
                                    : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= answer;
            prdata  <= answer ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            pslverr <= answer && !hit;
        end
    end

    // ---------------------------------------------------------------------
    // Register file
    // ---------------------------------------------------------------------
    // Unimplemented bits from the nonvolatile word are dropped by the mask, so
    // a writer that breaks its own programming convention changes nothing
    generate
        for (genvar i = 0; i < `DCWB_NUM_REGS; i++) begin : g_reg
            localparam logic [7:0] rst_byte =
                `DCWB_RESET_BYTE & mask_of(3'(i));
            wire logic [7:0] m = mask_of(3'(i));
            wire logic ld_hit  = ld_capture && (ld_idx_r == 3'(i));
            wire logic wr_hit  = commit && (hit_idx == 3'(i))
                                 && !written_r[i];
            always_comb begin
                cfg_nxt[i]     = cfg_r[i];
                written_nxt[i] = written_r[i] || wr_hit;
                if (ld_hit) begin
                    cfg_nxt[i] = nv_rd_data & m;
                end else if (wr_hit) begin
                    cfg_nxt[i] = pwdata[7:0] & m;
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cfg_r[i]     <= rst_byte;
                    written_r[i] <= 1'b0;
                end else begin
                    cfg_r[i]     <= cfg_nxt[i];
                    written_r[i] <= written_nxt[i];
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------------
    // Setting decode
    // ---------------------------------------------------------------------
    wire logic [1:0] div_code   = cfg_r[0][1:0];
    wire logic [2:0] osc_code   = cfg_r[1][2:0];
    wire logic [1:0] sosc_code  = cfg_r[1][4:3];
    wire logic [3:0] ds_code    = cfg_r[3][7:4];
    wire logic       ds_bor     = cfg_r[3][`DCWB_BIT_DS_BROWNOUT];
    wire logic [6:0] bnd_page   = cfg_r[5][6:0];
    wire logic       wp_cfg_n   = cfg_r[5][`DCWB_BIT_CFG_PAGE_PROTECT_N];
    wire logic       wp_dir     = cfg_r[6][`DCWB_BIT_RANGE_DIRECTION];
    wire logic       wp_dis     = cfg_r[6][`DCWB_BIT_PROTECT_DISABLE];
    wire logic       one_way    = cfg_r[4][`DCWB_BIT_PIN_LOCK_ONE_WAY];
    wire logic       ext_mode   = (osc_code[2:1] == 2'b11);
    dcwb_settings_s  set_nxt;

    always_comb begin
        set_nxt = '0;
        case (div_code)
            2'b11:   set_nxt.cpu_clock_divide_ratio = 3'h1;
            2'b10:   set_nxt.cpu_clock_divide_ratio = 3'h2;
            2'b01:   set_nxt.cpu_clock_divide_ratio = 3'h3;
            default: set_nxt.cpu_clock_divide_ratio = 3'h6;
        endcase
        set_nxt.code_protected =
            !cfg_r[0][`DCWB_BIT_CODE_PROTECT_N];
        set_nxt.two_speed_startup_en =
            cfg_r[1][`DCWB_BIT_TWO_SPEED];
        set_nxt.fail_safe_monitor_en =
            cfg_r[1][`DCWB_BIT_FAIL_SAFE];
        set_nxt.clock_out_signal_en =
            cfg_r[1][`DCWB_BIT_CLOCK_OUT_EN] && ext_mode;
        if (!osc_code[2]) begin
            set_nxt.osc_source  = DCWB_SRC_INTERNAL;
            set_nxt.osc_pll_sel = osc_code[1];
            set_nxt.clock_out_signal_en = osc_code[0];
        end else if (!osc_code[1]) begin
            set_nxt.osc_source  = DCWB_SRC_CRYSTAL;
            set_nxt.osc_pll_sel = osc_code[0];
        end else begin
            set_nxt.osc_source  = DCWB_SRC_EXTERNAL;
            set_nxt.osc_pll_sel = osc_code[0];
        end
        case (sosc_code)
            2'b11:   set_nxt.secondary_osc_power = DCWB_SOSC_HIGH_POWER;
            2'b10:   set_nxt.secondary_osc_power = DCWB_SOSC_DIGITAL;
            2'b01:   set_nxt.secondary_osc_power = DCWB_SOSC_LOW_POWER;
            default: set_nxt.secondary_osc_power = DCWB_SOSC_RESERVED;
        endcase
        set_nxt.watchdog_postscale_log2 = cfg_r[2][3:0];
        set_nxt.deep_sleep_wd_enable =
            cfg_r[3][`DCWB_BIT_DS_WD_ENABLE] && !lv_strap_r;
        set_nxt.deep_sleep_wd_postscale_log2 =
            {ds_code, 1'b1};
        // Low-voltage variants have no regulator and no deep-sleep split
        set_nxt.brownout_in_deep_sleep = ds_bor && !lv_strap_r;
        set_nxt.brownout_always        = ds_bor && lv_strap_r;
        set_nxt.rtc_ref_secondary = cfg_r[3][`DCWB_BIT_RTC_REF];
        set_nxt.deep_sleep_wd_ref_internal =
            cfg_r[3][`DCWB_BIT_DS_WD_REF];
        set_nxt.serial_addr_mask_7bit =
            cfg_r[4][`DCWB_BIT_ADDR_MASK_MODE];
        set_nxt.converter_10bit =
            cfg_r[4][`DCWB_BIT_CONVERTER_RES];
        set_nxt.pin_lock_one_way = one_way;
        set_nxt.low_speed_usb_divide =
            cfg_r[6][`DCWB_BIT_USB_LS_CLOCK] ? `DCWB_USB_DIV_48MHZ
                                             : `DCWB_USB_DIV_24MHZ;
    end

    // ---------------------------------------------------------------------
    // Flash protection query
    // ---------------------------------------------------------------------
    wire logic [6:0] q_page   = flash_byte_addr[16:`DCWB_FLASH_PAGE_SHIFT];
    wire logic       in_upper = (q_page >= bnd_page)
                                && (q_page <= `DCWB_CONFIG_PAGE);
    wire logic       in_range = wp_dir ? in_upper
                                       : (q_page <= bnd_page);
    wire logic       cfg_pg   = (q_page == `DCWB_CONFIG_PAGE)
                                && !wp_cfg_n;
    wire logic       prot_nxt = !wp_dis && (in_range || cfg_pg);

    // ---------------------------------------------------------------------
    // Pin-select lock
    // ---------------------------------------------------------------------
    // In one-way mode the clear request is simply dropped
    wire logic lock_set = pin_select_lock_set && pin_select_unlocked;
    wire logic lock_clr = pin_select_lock_clear && pin_select_unlocked
                          && !one_way;
    wire logic lock_nxt = lock_set ? 1'b1
                        : lock_clr ? 1'b0 : pin_select_lock;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settings               <= '0;
            flash_page_protected   <= 1'b0;
            pin_select_lock        <= 1'b0;
            pin_select_write_allow <= 1'b0;
        end else begin
            settings               <= set_nxt;
            flash_page_protected   <= prot_nxt;
            pin_select_lock        <= lock_nxt;
            pin_select_write_allow <= !lock_nxt && pin_select_unlocked;
        end
    end

    // ---------------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    cpu_div_map_a: assert property (div_code == 2'b00 |=>
        settings.cpu_clock_divide_ratio == 3'h6)
        else $error("cpu divide code 00 not decoded to 6");
    code_prot_a: assert property (!cfg_r[0][2] |=>
        settings.code_protected)
        else $error("code protect level wrong");
    write_once_a: assert property (commit && written_r[hit_idx]
        |=> cfg_r[$past(hit_idx)] == $past(cfg_r[hit_idx]))
        else $error("second write changed a register");
    unimpl_zero_a: assert property (pready && !pslverr
        |-> (prdata[7:0] & ~mask_of(hit_idx)) == 8'h00
            && prdata[31:8] == 24'h00_0000)
        else $error("unimplemented bits read nonzero");
    clkout_gate_a: assert property (osc_code[2:1] == 2'b10
        |=> !settings.clock_out_signal_en)
        else $error("clock out active in crystal mode");
    ds_post_a: assert property (ds_code == 4'hF
        |=> settings.deep_sleep_wd_postscale_log2 == 5'h1F)
        else $error("deep sleep postscale wrong");
    flash_dis_a: assert property (wp_dis |=> !flash_page_protected)
        else $error("protection active while disabled");
    load_once_a: assert property (load_done
        |=> load_done && !nv_rd_en)
        else $error("configuration load restarted");
    load_time_a: assert property ($rose(load_done)
        |-> $past(ld_idx_r) == 3'(`DCWB_NUM_REGS - 1))
        else $error("load ended before all registers");
    one_way_a: assert property (one_way && pin_select_lock
        |=> pin_select_lock)
        else $error("one-way pin lock cleared");
    usb_div_a: assert property (!cfg_r[6][3] |=>
        settings.low_speed_usb_divide == `DCWB_USB_DIV_24MHZ)
        else $error("low speed usb divide wrong");
    sosc_res_a: assert property (sosc_code == 2'b00 |=>
        settings.secondary_osc_power == DCWB_SOSC_RESERVED)
        else $error("reserved secondary oscillator code not kept");
    int_pll_a: assert property (osc_code == 3'b010 |=>
        settings.osc_pll_sel && !settings.clock_out_signal_en)
        else $error("internal pll mode decoded wrong");
    lv_bor_a: assert property (lv_strap_r && ds_bor |=>
        settings.brownout_always && !settings.brownout_in_deep_sleep)
        else $error("low voltage brown-out not always on");
    lock_hold_a: assert property (!pin_select_unlocked |=>
        pin_select_lock == $past(pin_select_lock))
        else $error("pin lock moved while locked out");
    cfg_page_a: assert property (!wp_dis && !wp_cfg_n
        && q_page == `DCWB_CONFIG_PAGE |=> flash_page_protected)
        else $error("configuration page left unprotected");

    load_end_c: cover property ($rose(load_done));
    lock_set_c: cover property ($rose(pin_select_lock));
    write_once_c: cover property (commit ##2 access ##1 commit);
    protected_c: cover property (flash_page_protected && wp_dir);
    error_c: cover property (pready && pslverr);
endmodule : dcwb_config_bank
`default_nettype wire

// file: dv/test_dcwb_config_bank.sv
// Self-checking bench of the configuration word bank
`default_nettype none
module test_dcwb_config_bank;
    timeunit 1ns;
    timeprecision 1ps;
    import dcwb_pkg::*;
    // ---------------------------------------------------------------
    // Stimulus state
    // ---------------------------------------------------------------
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [23:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, seed = 3505;
    logic        pready, pslverr, nv_rd_en, load_done, prot, er;
    logic [2:0]  nv_rd_index;
    logic [7:0]  nv_rd_data = 0, w, nvb[7], r[7];
    logic [16:0] flash_byte_addr = 0;
    logic        lv = 0, lock, wal, lk = 0;
    logic [2:0]  pin = 0;
    dcwb_settings_s s;
    int          n_mismatch = 0, n_tests = 0;
    localparam logic [7:0] MSK[7] = '{8'h07, 8'hFF, 8'h0F, 8'hFF, 8'h0B,
                                      8'hFF, 8'h0B};
    dcwb_config_bank u_dcwb_config_bank (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .nv_rd_en(nv_rd_en), .nv_rd_index(nv_rd_index),
        .nv_rd_data(nv_rd_data), .load_done(load_done),
        .low_voltage_variant(lv), .pin_select_unlocked(pin[2]),
        .pin_select_lock_set(pin[1]), .pin_select_lock_clear(pin[0]),
        .pin_select_lock(lock), .pin_select_write_allow(wal),
        .flash_byte_addr(flash_byte_addr), .flash_page_protected(prot),
        .settings(s));
    initial forever #12.5 pclk = ~pclk;
    // Idle data is inverted so a late capture shows up as a mismatch
    always @(posedge pclk)
        nv_rd_data <= nv_rd_en ? nvb[nv_rd_index] : ~nv_rd_data;
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic logic [2:0] cpu_div(input logic [1:0] c);
        return c == 2'h3 ? 3'h1 : c == 2'h2 ? 3'h2 : c == 2'h1 ? 3'h3 : 3'h6;
    endfunction : cpu_div
    function automatic logic [3:0] osc_exp(input logic [7:0] c);
        if (!c[2]) return {DCWB_SRC_INTERNAL, c[1], c[0]};
        if (!c[1]) return {DCWB_SRC_CRYSTAL, c[0], 1'b0};
        return {DCWB_SRC_EXTERNAL, c[0], c[5]};
    endfunction : osc_exp
    function automatic logic [3:0] osc_seen();
        return {s.osc_source, s.osc_pll_sel, s.clock_out_signal_en};
    endfunction : osc_seen
    function automatic dcwb_sosc_e sosc_exp(input logic [1:0] c);
        case (c)
            2'b11:   return DCWB_SOSC_HIGH_POWER;
            2'b10:   return DCWB_SOSC_DIGITAL;
            2'b01:   return DCWB_SOSC_LOW_POWER;
            default: return DCWB_SOSC_RESERVED;
        endcase
    endfunction : sosc_exp
    function automatic logic page_prot(input logic [6:0] p);
        if (r[6][0]) return 1'b0;
        return (p == 7'h3F && !r[5][7]) ||
               (r[6][1] ? p >= r[5][6:0] : p <= r[5][6:0]);
    endfunction : page_prot
    task automatic chk(input string nm, input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [2:0] i,
                       input logic [7:0] d, input logic bad = 1'b0);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {bad ? 22'h300000 : 22'h300001 + i, 2'b00};
        pwdata <= {24'(xs()), d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 60) begin
            @(posedge pclk);
            n++;
        end
        chk("pready", n < 60, 1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic check_all();
        foreach (r[i]) begin
            apb(1'b0, 3'(i), 8'h00);
            chk("reg", rd, {24'h0, r[i]});
        end
        apb(1'b0, 3'h0, 8'h00, 1'b1);
        chk("slverr", er, 1);
        chk("errdata", rd, 0);
        chk("osc", osc_seen(), osc_exp(r[1]));
        chk("sosc", s.secondary_osc_power, sosc_exp(r[1][4:3]));
        chk("bords", s.brownout_in_deep_sleep, r[3][2] && !lv);
        chk("boral", s.brownout_always, r[3][2] && lv);
        chk("dsref", s.deep_sleep_wd_ref_internal, r[3][0]);
        chk("oneway", s.pin_lock_one_way, r[4][0]);
        chk("div", s.cpu_clock_divide_ratio, cpu_div(r[0][1:0]));
        chk("cp", s.code_protected, !r[0][2]);
        chk("ts", s.two_speed_startup_en, r[1][7]);
        chk("fs", s.fail_safe_monitor_en, r[1][6]);
        chk("wd", s.watchdog_postscale_log2, r[2][3:0]);
        chk("dsen", s.deep_sleep_wd_enable, r[3][3] && !lv);
        chk("ds", s.deep_sleep_wd_postscale_log2, {r[3][7:4],1'b1});
        chk("rtc", s.rtc_ref_secondary, r[3][1]);
        chk("msk", s.serial_addr_mask_7bit, r[4][3]);
        chk("adc", s.converter_10bit, r[4][1]);
        chk("usb", s.low_speed_usb_divide, r[6][3] ? 8 : 4);
        for (int k = 0; k < 8; k++) begin
            flash_byte_addr <= k ? {1'b0, 16'(xs())} : 17'h0FC00;
            // Set then clear first, the rest drawn at random
            pin <= k == 0 ? 3'b110 : k == 1 ? 3'b101 : 3'(xs());
            @(posedge pclk);
            @(posedge pclk);
            chk("prot", prot, page_prot(flash_byte_addr[16:10]));
            if (pin[2] && pin[1])
                lk = 1'b1;
            else if (pin[2] && pin[0] && !r[4][0])
                lk = 1'b0;
            chk("lock", lock, lk);
            chk("allow", wal, !lk && pin[2]);
        end
        // Idle requests, so a later one-way change cannot move the lock
        pin <= 3'b000;
    endtask : check_all
    task automatic end_of_test();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    // ---------------------------------------------------------------
    // Sequence: reload twice, first read stalls behind the load
    // ---------------------------------------------------------------
    initial begin
        for (int k = 0; k < 2; k++) begin
            presetn <= 1'b0;
            lv <= k[0];
            lk = 1'b0;
            foreach (nvb[i])
                nvb[i] = i[0] ? 8'(xs()) : {4'hF, 4'(xs())};
            nvb[0][3] = 1'b0;
            foreach (r[i]) r[i] = nvb[i] & MSK[i];
            repeat (5) @(posedge pclk);
            presetn <= 1'b1;
            check_all();
            chk("load_done", load_done, 1);
            foreach (r[i]) begin
                w = 8'(xs());
                apb(1'b1, 3'(i), w);
                apb(1'b1, 3'(i), ~w);
                r[i] = w & MSK[i];
            end
            check_all();
        end
        end_of_test();
    end
    initial begin
        repeat (5000) @(posedge pclk);
        n_mismatch++;
        end_of_test();
    end
endmodule : test_dcwb_config_bank
`default_nettype wire
